// ---- poe_port_timing.sv ----
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "poe_defines.svh"
module poe_port_timing #(
    parameter int PORTS      = 4,
    parameter int TICK_DIV   = `POE_TICK_US * `POE_CLK_MHZ,
    parameter int SHORT_HOLD = `POE_SHORT_HOLD_US * `POE_CLK_MHZ
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [9:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output var  logic [31:0]        prdata,
    output var  logic               pready,
    output var  logic               pslverr,
    input  wire logic [PORTS-1:0]   senseAboveCut,
    input  wire logic [PORTS-1:0]   senseAboveLimit,
    input  wire logic [PORTS-1:0]   senseAboveShort,
    input  wire logic [PORTS-1:0]   outAbovePowerGood,
    input  wire logic [PORTS*8-1:0] outVoltage,
    input  wire logic [PORTS-1:0]   detectGood,
    output wire logic [PORTS-1:0]   portPowerOn,
    output wire logic [PORTS-1:0]   gatePullDown,
    output wire logic [PORTS-1:0]   gateReduce,
    output wire logic [PORTS-1:0]   disconnectTimerEnable,
    output wire logic [PORTS*9-1:0] limitThreshold
);
    localparam int CW = 12;
    localparam int LW = 9;
    localparam int VW = 8;
    localparam int TW = $clog2(TICK_DIV);
    localparam int HW = $clog2(SHORT_HOLD);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_DIV - 1);
    localparam logic [HW-1:0] HOLD_LAST = HW'(SHORT_HOLD - 1);

    // status fields are four bits wide, so four ports at most
    if (PORTS < 1 || PORTS > 4 ||
        TICK_DIV < 2 || SHORT_HOLD < 2) begin : gBadParam
        $error("poe_port_timing: unsupported parameter value");
    end

    logic [31:0]             prdata_ff;
    logic                    pready_ff;
    logic                    pslverr_ff;
    logic [`POE_TIMING_W-1:0] timing_ff;
    logic [`POE_MODE_W-1:0]   mode_ff;
    logic [TW-1:0]           tickCnt_ff;
    logic                    tick_ff;

    logic [PORTS-1:0] ocFaultVec;
    logic [PORTS-1:0] stFaultVec;
    logic [PORTS-1:0] zeroVec;
    logic [PORTS-1:0] startVec;
    logic [PORTS-1:0] cmdOn;
    logic [PORTS-1:0] cmdOff;
    logic [PORTS-1:0] faultClr;
    logic [7:0]       idx;
    logic             setup;
    logic             wrDone;
    logic             aligned;
    logic [31:0]      rdData;
    logic             unmapped;
    logic [CW-1:0]    cutFull;
    logic [CW-1:0]    startFull;

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

    assign idx     = paddr[9:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setup   = psel && !penable;
    assign wrDone  = psel && penable && pready_ff && pwrite && aligned;

    // common timebase shared by all ports
    always_ff @(posedge clk) begin
        if (rst) begin
            tickCnt_ff <= '0;
            tick_ff    <= 1'b0;
        end else begin
            tick_ff <= (tickCnt_ff == TICK_LAST);
            if (tickCnt_ff == TICK_LAST) begin
                tickCnt_ff <= '0;
            end else begin
                tickCnt_ff <= tickCnt_ff + 1'b1;
            end
        end
    end

    always_comb begin
        unique case (timing_ff[`POE_T_CUT_LSB +: 2])
            2'h0: cutFull = `POE_CUT_FULL0;
            2'h1: cutFull = `POE_CUT_FULL1;
            2'h2: cutFull = `POE_CUT_FULL2;
            2'h3: cutFull = `POE_CUT_FULL3;
        endcase
        unique case (timing_ff[`POE_T_START_LSB +: 2])
            2'h0: startFull = `POE_START_FULL0;
            2'h1: startFull = `POE_START_FULL1;
            2'h2: startFull = `POE_START_FULL2;
            2'h3: startFull = `POE_START_FULL3;
        endcase
    end

    // apb slave: one wait state, answer in the second access cycle
    always_comb begin
        rdData   = '0;
        unmapped = !aligned;
        case (idx)
            `POE_IDX_FAULT, `POE_IDX_FAULT_CLR: begin
                rdData[`POE_F_OC_LSB +: PORTS] = ocFaultVec;
                rdData[`POE_F_ST_LSB +: PORTS] = stFaultVec;
            end
            `POE_IDX_STATUS: begin
                rdData[`POE_S_PWR_LSB +: PORTS]   = portPowerOn;
                rdData[`POE_S_ZERO_LSB +: PORTS]  = zeroVec;
                rdData[`POE_S_START_LSB +: PORTS] = startVec;
                rdData[`POE_S_SHORT_LSB +: PORTS] = gatePullDown;
            end
            `POE_IDX_MODE:    rdData[`POE_MODE_W-1:0] = mode_ff;
            `POE_IDX_TIMING:  rdData[`POE_TIMING_W-1:0] = timing_ff;
            `POE_IDX_COMMAND: rdData = '0;
            default:          unmapped = 1'b1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end else begin
            pready_ff  <= psel && penable && !pready_ff;
            pslverr_ff <= psel && penable && !pready_ff && unmapped;
            if (psel && penable && !pready_ff && !pwrite) begin
                prdata_ff <= rdData;
            end else if (setup) begin
                prdata_ff <= '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            timing_ff <= `POE_TIMING_RST;
            mode_ff   <= `POE_MODE_RST;
        end else if (wrDone) begin
            if (idx == `POE_IDX_TIMING) begin
                timing_ff <= pwdata[`POE_TIMING_W-1:0];
            end
            if (idx == `POE_IDX_MODE) begin
                mode_ff <= pwdata[`POE_MODE_W-1:0];
            end
        end
    end

    assign cmdOn    = (wrDone && idx == `POE_IDX_COMMAND) ?
                      pwdata[`POE_C_ON_LSB +: PORTS] : '0;
    assign cmdOff   = (wrDone && idx == `POE_IDX_COMMAND) ?
                      pwdata[`POE_C_OFF_LSB +: PORTS] : '0;
    assign faultClr = (wrDone && idx == `POE_IDX_FAULT_CLR) ?
                      (pwdata[`POE_F_OC_LSB +: PORTS] |
                       pwdata[`POE_F_ST_LSB +: PORTS]) : '0;

    for (genvar g = 0; g < PORTS; g++) begin : gPort
        logic [CW-1:0]        ocCount_ff;
        logic [3:0]           downDiv_ff;
        logic [CW-1:0]        startElapsed_ff;
        logic                 startRun_ff;
        logic                 allInLimit_ff;
        logic                 powered_ff;
        logic                 ocFault_ff;
        logic                 stFault_ff;
        logic                 pullDown_ff;
        logic [HW-1:0]        hold_ff;
        logic                 reduce_ff;
        logic                 discEn_ff;
        logic [LW-1:0]        limit_ff;
        logic                 upCond;
        logic                 atZero;
        logic                 expired;
        logic                 powerUpReq;
        logic                 stClass;
        logic [CW-1:0]        fullCount;
        logic [VW-1:0]        vOut;
        logic [LW+VW-1:0]     fbProd;
        logic [LW+VW-1:0]     fbQuot;
        logic [LW-1:0]        nxt_limit;
        poe_pkg::poe_mode_type mode;

        assign mode = poe_pkg::poe_mode_type'(mode_ff[2*g +: 2]);
        // foldback does not mask either up-count term
        assign upCond = powered_ff &&
                        (senseAboveCut[g] || outAbovePowerGood[g]);
        assign fullCount = startRun_ff ? startFull : cutFull;
        assign atZero  = (ocCount_ff == '0);
        // >= covers a shorter duration written while counting
        assign expired = powered_ff && (ocCount_ff >= fullCount);
        assign stClass = startRun_ff && allInLimit_ff;

        assign powerUpReq = !powered_ff && atZero &&
            ((mode == poe_pkg::POE_MODE_AUTO && detectGood[g]) ||
             ((mode == poe_pkg::POE_MODE_MANUAL ||
               mode == poe_pkg::POE_MODE_SEMIAUTO) && cmdOn[g]));

        always_ff @(posedge clk) begin
            if (rst) begin
                ocCount_ff <= '0;
                downDiv_ff <= '0;
            end else if (tick_ff) begin
                if (upCond) begin
                    downDiv_ff <= '0;
                    if (ocCount_ff < fullCount) begin
                        ocCount_ff <= ocCount_ff + 1'b1;
                    end
                end else begin
                    downDiv_ff <= downDiv_ff + 1'b1;
                    if (downDiv_ff == `POE_DOWN_LAST && !atZero) begin
                        ocCount_ff <= ocCount_ff - 1'b1;
                    end
                end
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                powered_ff <= 1'b0;
            end else if (mode == poe_pkg::POE_MODE_SHUTDOWN || cmdOff[g] ||
                         expired) begin
                powered_ff <= 1'b0;
            end else if (powerUpReq) begin
                powered_ff <= 1'b1;
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                startRun_ff     <= 1'b0;
                startElapsed_ff <= '0;
                allInLimit_ff   <= 1'b0;
            end else if (powerUpReq) begin
                startRun_ff     <= 1'b1;
                startElapsed_ff <= '0;
                allInLimit_ff   <= 1'b1;
            end else if (!powered_ff) begin
                startRun_ff <= 1'b0;
            end else if (startRun_ff) begin
                if (!senseAboveLimit[g]) begin
                    allInLimit_ff <= 1'b0;
                end
                // stay one cycle past the last tick so expiry is classed
                if (startElapsed_ff >= startFull) begin
                    startRun_ff <= 1'b0;
                end else if (tick_ff) begin
                    startElapsed_ff <= startElapsed_ff + 1'b1;
                end
            end
        end

        // set wins over a same-cycle clear
        always_ff @(posedge clk) begin
            if (rst) begin
                ocFault_ff <= 1'b0;
                stFault_ff <= 1'b0;
            end else begin
                if (expired && !stClass) begin
                    ocFault_ff <= 1'b1;
                end else if (faultClr[g]) begin
                    ocFault_ff <= 1'b0;
                end
                if (expired && stClass) begin
                    stFault_ff <= 1'b1;
                end else if (faultClr[g]) begin
                    stFault_ff <= 1'b0;
                end
            end
        end

        // gate held low for SHORT_HOLD cycles, not retriggered meanwhile
        always_ff @(posedge clk) begin
            if (rst) begin
                pullDown_ff <= 1'b0;
                hold_ff     <= '0;
            end else if (!pullDown_ff) begin
                if (powered_ff && senseAboveShort[g]) begin
                    pullDown_ff <= 1'b1;
                    hold_ff     <= HOLD_LAST;
                end
            end else if (hold_ff == '0) begin
                pullDown_ff <= 1'b0;
            end else begin
                hold_ff <= hold_ff - 1'b1;
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                reduce_ff <= 1'b0;
                discEn_ff <= 1'b0;
            end else begin
                reduce_ff <= powered_ff && senseAboveLimit[g];
                discEn_ff <= powered_ff && !startRun_ff && !powerUpReq;
            end
        end

        assign vOut   = outVoltage[g*VW +: VW];
        assign fbProd = (LW+VW)'(`POE_FB_FULL - `POE_FB_FLOOR) * vOut;
        assign fbQuot = fbProd / `POE_FB_KNEE;
        assign nxt_limit = (vOut >= `POE_FB_KNEE) ? `POE_FB_FULL :
                           `POE_FB_FLOOR + fbQuot[LW-1:0];

        always_ff @(posedge clk) begin
            if (rst) begin
                limit_ff <= `POE_FB_FLOOR;
            end else begin
                limit_ff <= nxt_limit;
            end
        end

        assign portPowerOn[g]           = powered_ff;
        assign gatePullDown[g]          = pullDown_ff;
        assign gateReduce[g]            = reduce_ff;
        assign disconnectTimerEnable[g] = discEn_ff;
        assign limitThreshold[g*LW +: LW] = limit_ff;
        assign ocFaultVec[g] = ocFault_ff;
        assign stFaultVec[g] = stFault_ff;
        assign zeroVec[g]    = atZero;
        assign startVec[g]   = startRun_ff;
    end
endmodule
`default_nettype wire

// ---- poe_defines.svh ----
`ifndef POE_DEFINES_SVH
`define POE_DEFINES_SVH

`define POE_CLK_MHZ        250
`define POE_TICK_US        100
`define POE_SHORT_HOLD_US  100

// register indices, byte address is four times the index
`define POE_IDX_FAULT      8'h06
`define POE_IDX_FAULT_CLR  8'h07
`define POE_IDX_STATUS     8'h10
`define POE_IDX_MODE       8'h12
`define POE_IDX_TIMING     8'h16
`define POE_IDX_COMMAND    8'h19

`define POE_F_OC_LSB       0
`define POE_F_ST_LSB       4
`define POE_S_PWR_LSB      0
`define POE_S_ZERO_LSB     4
`define POE_S_START_LSB    8
`define POE_S_SHORT_LSB    12
`define POE_C_ON_LSB       0
`define POE_C_OFF_LSB      4
`define POE_T_DIS_LSB      0
`define POE_T_CUT_LSB      2
`define POE_T_START_LSB    4
`define POE_TIMING_W       6
`define POE_MODE_W         8
`define POE_TIMING_RST     6'h00
`define POE_MODE_RST       8'h00

// durations in timebase ticks, selected by a two-bit field
`define POE_CUT_FULL0      12'h177
`define POE_CUT_FULL1      12'h2EE
`define POE_CUT_FULL2      12'h5DC
`define POE_CUT_FULL3      12'hBB8
`define POE_START_FULL0    12'h12C
`define POE_START_FULL1    12'h258
`define POE_START_FULL2    12'h4B0
`define POE_START_FULL3    12'h960
`define POE_DOWN_LAST      4'hF

// foldback: limit in 0.5 mV steps, voltage in 0.1 V steps
`define POE_FB_FULL        9'h1A9
`define POE_FB_FLOOR       9'h03C
`define POE_FB_KNEE        8'hB4

`endif

// ---- poe_pkg.sv ----
`default_nettype none
package poe_pkg;
    typedef enum logic [1:0] {
        POE_MODE_SHUTDOWN,
        POE_MODE_MANUAL,
        POE_MODE_SEMIAUTO,
        POE_MODE_AUTO
    } poe_mode_type;
endpackage
`default_nettype wire

// ---- poe_fet_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// external switch and powered load: no current flows while the port is off
module poe_fet_model #(
    parameter int PORTS = 4
) (
    input  wire logic [PORTS-1:0]   portPowerOn,
    input  wire logic [PORTS-1:0]   gatePullDown,
    input  wire logic [PORTS-1:0]   heavy,
    input  wire logic [PORTS-1:0]   shortReq,
    input  wire logic [PORTS-1:0]   pgHigh,
    input  wire logic [PORTS*8-1:0] vset,
    output logic      [PORTS-1:0]   senseAboveCut,
    output logic      [PORTS-1:0]   senseAboveLimit,
    output logic      [PORTS-1:0]   senseAboveShort,
    output logic      [PORTS-1:0]   outAbovePowerGood,
    output logic      [PORTS*8-1:0] outVoltage
);
    // an overload sits at the limit, never beyond it
    assign senseAboveCut = portPowerOn & heavy & ~gatePullDown;
    assign senseAboveLimit = portPowerOn & heavy & ~gatePullDown;
    // a pulled-down gate stops the short current at once
    assign senseAboveShort = portPowerOn & shortReq & ~gatePullDown;
    assign outAbovePowerGood = portPowerOn & pgHigh;
    always_comb begin
        for (int g = 0; g < PORTS; g++) begin
            outVoltage[8*g +: 8] = portPowerOn[g] ? vset[8*g +: 8] : 8'h00;
        end
    end
endmodule
`default_nettype wire

// ---- poe_port_timing_props.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "poe_defines.svh"
module poe_port_timing_props #(
    parameter int PORTS      = 4,
    parameter int TICK_DIV   = 4,
    parameter int SHORT_HOLD = 4
) (
    input wire logic               clk,
    input wire logic               rst,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [9:0]         paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic [PORTS-1:0]   senseAboveCut,
    input wire logic [PORTS-1:0]   senseAboveLimit,
    input wire logic [PORTS-1:0]   senseAboveShort,
    input wire logic [PORTS-1:0]   outAbovePowerGood,
    input wire logic [PORTS*8-1:0] outVoltage,
    input wire logic [PORTS-1:0]   detectGood,
    input wire logic [PORTS-1:0]   portPowerOn,
    input wire logic [PORTS-1:0]   gatePullDown,
    input wire logic [PORTS-1:0]   gateReduce,
    input wire logic [PORTS-1:0]   disconnectTimerEnable,
    input wire logic [PORTS*9-1:0] limitThreshold
);
    logic [PORTS-1:0] shortCause;
    logic             onReq0;
    logic [15:0]      pdCnt_ff;
    assign shortCause = portPowerOn & ~gatePullDown & senseAboveShort;
    assign onReq0 = detectGood[0] | (psel & penable & pready & pwrite
        & pwdata[0] & (paddr == {`POE_IDX_COMMAND, 2'b00}));
    // length of the current pull-down on port 0
    always_ff @(posedge clk) begin
        if (rst || !gatePullDown[0]) begin
            pdCnt_ff <= 16'h0000;
        end else begin
            pdCnt_ff <= pdCnt_ff + 16'h0001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer late");
    property p_one;
        pready |=> !pready;
    endproperty
    a_one: assert property (p_one) else $error("bus answer too long");
    property p_err;
        psel && penable && pready && paddr[1:0] != 2'b00 |-> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("misaligned not refused");
    property p_rdat;
        psel && !penable |=> prdata == 32'h0;
    endproperty
    a_rdat: assert property (p_rdat) else $error("read data not idle");
    property p_short;
        shortCause != '0 |=> (gatePullDown & $past(shortCause)) == $past(shortCause);
    endproperty
    a_short: assert property (p_short) else $error("no fast pull-down");
    property p_hold;
        $fell(gatePullDown[0]) |-> pdCnt_ff == SHORT_HOLD;
    endproperty
    a_hold: assert property (p_hold) else $error("pull-down length wrong");
    property p_reduce;
        gateReduce == $past(portPowerOn & senseAboveLimit);
    endproperty
    a_reduce: assert property (p_reduce) else $error("gate reduce wrong");
    property p_dis;
        $rose(portPowerOn[0]) |-> (!disconnectTimerEnable[0]) [*8];
    endproperty
    a_dis: assert property (p_dis) else $error("disconnect early");
    property p_dis_off;
        disconnectTimerEnable[0] |-> portPowerOn[0] || $past(portPowerOn[0]);
    endproperty
    a_dis_off: assert property (p_dis_off) else $error("disconnect unpowered");
    property p_on;
        $rose(portPowerOn[0]) |-> $past(onReq0) || $past(onReq0, 2);
    endproperty
    a_on: assert property (p_on) else $error("power without request");
    c_short: cover property ($rose(gatePullDown[0]));
    c_err: cover property (pready && pslverr);
    c_off: cover property ($fell(portPowerOn[0]));
endmodule
bind poe_port_timing poe_port_timing_props #(
    .PORTS(PORTS), .TICK_DIV(TICK_DIV), .SHORT_HOLD(SHORT_HOLD)
) uProps (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .senseAboveCut(senseAboveCut),
    .senseAboveLimit(senseAboveLimit), .senseAboveShort(senseAboveShort),
    .outAbovePowerGood(outAbovePowerGood), .outVoltage(outVoltage),
    .detectGood(detectGood), .portPowerOn(portPowerOn),
    .gatePullDown(gatePullDown), .gateReduce(gateReduce),
    .disconnectTimerEnable(disconnectTimerEnable),
    .limitThreshold(limitThreshold)
);
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "poe_defines.svh"
module tb;
    localparam int HOLD = 8;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, vOut, vset;
    logic [3:0]  sCut, sLim, sShort, pgOut, detectGood, powerOn, pullDown;
    logic [3:0]  reduce, disEn, heavy, shortReq, pgHigh;
    logic [35:0] limitThr;
    logic [32:0] expQ[$];
    logic [7:0]  v;
    int          bad_count, compares, seed, n, i;
    poe_port_timing #(.TICK_DIV(4), .SHORT_HOLD(HOLD)) uut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .senseAboveCut(sCut),
        .senseAboveLimit(sLim), .senseAboveShort(sShort),
        .outAbovePowerGood(pgOut), .outVoltage(vOut),
        .detectGood(detectGood), .portPowerOn(powerOn),
        .gatePullDown(pullDown), .gateReduce(reduce),
        .disconnectTimerEnable(disEn), .limitThreshold(limitThr));
    poe_fet_model uFet (
        .portPowerOn(powerOn), .gatePullDown(pullDown), .heavy(heavy),
        .shortReq(shortReq), .pgHigh(pgHigh), .vset(vset),
        .senseAboveCut(sCut), .senseAboveLimit(sLim),
        .senseAboveShort(sShort), .outAbovePowerGood(pgOut),
        .outVoltage(vOut));
    always #2 clk = ~clk;
    function automatic logic [9:0] ad(input logic [7:0] idx);
        return {idx, 2'b00};
    endfunction
    function automatic logic [8:0] fold(input logic [7:0] x);
        if (x >= 8'hB4) return 9'h1A9;
        return 9'(32'h3C + (32'h16D * x) / 32'hB4);
    endfunction
    task automatic chk_bus(input logic [32:0] e, input logic [32:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected bus answer exp %h seen %h", e, g);
        end
    endtask
    task automatic chk_port(input string nm, input logic [8:0] e,
                            input logic [8:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s exp %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [9:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        expQ.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    always @(posedge clk) begin
        if (psel && penable && pready) begin
            chk_bus(expQ.pop_front(), {pslverr, prdata});
        end
    end
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        end_sim();
    end
    initial begin
        clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0;
        pwdata = 0; detectGood = 0; heavy = 0; shortReq = 0; pgHigh = 0;
        vset = 0; seed = 85; bad_count = 0; compares = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(0, ad(`POE_IDX_TIMING), 32'h0, 33'h0);
        apb(0, ad(`POE_IDX_MODE), 32'h0, 33'h0);
        apb(0, ad(`POE_IDX_FAULT), 32'h0, 33'h0);
        apb(0, ad(`POE_IDX_STATUS), 32'h0, 33'h0F0);
        apb(0, 10'h3FC, 32'h0, 33'h100000000);
        apb(0, 10'h059, 32'h0, 33'h100000000);
        apb(1, ad(`POE_IDX_TIMING), 32'hFF, 33'h0);
        apb(0, ad(`POE_IDX_TIMING), 32'h0, 33'h03F);
        apb(1, ad(`POE_IDX_TIMING), 32'h0, 33'h0);
        apb(1, ad(`POE_IDX_MODE), 32'h39, 33'h0);
        $display("test registers done");
        heavy <= 4'h1;
        repeat (20) @(posedge clk);
        chk_port("power", 9'h000, powerOn);
        detectGood <= 4'h4;
        @(posedge clk);
        detectGood <= 4'h0;
        apb(1, ad(`POE_IDX_COMMAND), 32'h0B, 33'h0);
        repeat (3) @(posedge clk);
        chk_port("power", 9'h007, powerOn);
        chk_port("disconnect enable", 9'h000, disEn);
        repeat (1250) @(posedge clk);
        chk_port("power", 9'h006, powerOn);
        chk_port("disconnect enable", 9'h006, disEn);
        apb(0, ad(`POE_IDX_FAULT), 32'h0, 33'h010);
        $display("test startup done");
        heavy <= 4'h3;
        pgHigh <= 4'h4;
        apb(1, ad(`POE_IDX_COMMAND), 32'h01, 33'h0);
        for (i = 0; i < 8; i++) begin
            v = 8'($random(seed));
            vset <= {8'h00, v, 16'h0000};
            repeat (3) @(posedge clk);
            chk_port("limit", fold(v), limitThr[26:18]);
        end
        chk_port("limit idle", 9'h03C, limitThr[35:27]);
        repeat (1330) @(posedge clk);
        chk_port("power", 9'h006, powerOn);
        repeat (250) @(posedge clk);
        chk_port("power", 9'h000, powerOn);
        apb(0, ad(`POE_IDX_FAULT), 32'h0, 33'h016);
        $display("test overcurrent done");
        heavy <= 4'h0;
        pgHigh <= 4'h0;
        n = 0;
        while (powerOn[0] !== 1'b1 && n < 60) begin
            apb(1, ad(`POE_IDX_COMMAND), 32'h01, 33'h0);
            repeat (500) @(posedge clk);
            n++;
        end
        chk_port("lockout", 9'h001, 9'((n > 30) && (n < 42)));
        apb(0, ad(`POE_IDX_STATUS), 32'h0, 33'h191);
        apb(1, ad(`POE_IDX_FAULT_CLR), 32'h01, 33'h0);
        apb(0, ad(`POE_IDX_FAULT), 32'h0, 33'h006);
        $display("test lockout done");
        shortReq <= 4'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pullDown[0] !== 1'b1 && n < 20);
        shortReq <= 4'h0;
        n = 1;
        while (n < 40) begin
            @(posedge clk);
            if (pullDown[0] !== 1'b1) break;
            n++;
        end
        chk_port("pull-down cycles", 9'(HOLD), 9'(n));
        chk_port("power", 9'h001, powerOn);
        $display("test short done");
        end_sim();
    end
endmodule
`default_nettype wire
